// [rtl/srac_top.v]
// Security register access: four 256-byte OTP registers behind SPI.
// Assumes SPI mode 0 pins from a host, sampled by CLK_SYS which runs
// well above the serial clock; write enable latch lives elsewhere.
// Operation
// R1: four independent 256-byte registers
// R2: erase needs write enable latch set
// R3: host sends 44h plus 24-bit address
// R4: address checked: 00h, reg 0-3, 0000
// R5: host prefers registers 1-3
// R6: erase only if frame ends on byte
// R7: chip select rise starts timed erase
// R8: busy high during cycle, status readable
// R9: erase completion clears write enable latch
// R10: lock bit blocks erase
// R11: lock bit blocks program
// R12: program one to 256 bytes, erased targets
// R13: program needs write enable latch set
// R14: host sends 42h, address, data bytes
// R15: host sends 48h, address, dummy byte
// R16: sample on rise, drive on fall
// R17: read offset increments, wraps at FFh
// R18: read ignored while busy
// R19: read streams until chip select high
// R20: program cycle busy then clear latch
// R21: program only clears bits, wraps offset
`default_nettype none
`include "srac_defines.vh"
module srac_top #(
    parameter ERASE_CYC = `SRAC_ERASE_TIME_US * `SRAC_CLK_MHZ,
    parameter PROG_CYC = `SRAC_PROG_TIME_US * `SRAC_CLK_MHZ
) (
    // System clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // Serial link pins
    input wire SPI_CS_N,
    input wire SPI_SCK,
    input wire SPI_SI,
    output reg SPI_SO,
    output reg SPI_SO_OE,
    // Device status links
    input wire WRITE_ENABLE_LATCH,
    input wire [3:0] SECURITY_LOCK_BITS,
    input wire OTHER_BUSY,
    output reg WEL_CLEAR,
    output reg SEC_BUSY
);
    // Storage, erased on reset as a simulation stand-in for flash
    reg [7:0] mem [0:1023];
    // Synchronised pins: {cs_n, sck, si}
    wire [2:0] pins_s;
    wire cs_n_s = pins_s[2];
    wire sck_s = pins_s[1];
    wire si_s = pins_s[0];
    reg sck_d_r; // Previous settled clock
    reg cs_d_r; // Previous settled chip select
    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire cs_rise = cs_n_s & ~cs_d_r;
    // Frame state
    reg [5:0] bcnt_r; // Bits seen in header
    reg [7:0] op_r; // Opcode
    reg [23:0] adr_r; // Address shift
    reg [2:0] bit_r; // Bit within data byte
    reg [7:0] shin_r; // Incoming data byte
    reg [7:0] shout_r; // Outgoing data byte
    reg [7:0] off_r; // Byte offset
    reg in_data_r; // Past header
    reg frame_ok_r; // Frame accepted at start
    reg byte_edge_r; // Frame ends on byte boundary
    // Program buffer
    reg [7:0] pbuf [0:255];
    reg [255:0] pval_r; // Bytes loaded
    // Cycle engine
    localparam ST_IDLE = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_PROG = 2'h2;
    reg [1:0] st_r;
    reg [31:0] tmr_r;
    reg [1:0] sel_r; // Target register of the cycle
    reg [8:0] idx_r; // Walk index during cycle
    integer i;

    // Address field check
    function adr_valid;
        input [23:0] a;
        begin
            adr_valid = (a[23:16] == `SRAC_ADR_HI_VAL) &&
                (a[11:8] == `SRAC_ADR_MID_VAL) &&
                (a[15:12] <= `SRAC_REG_MAX); // R4
        end
    endfunction

    // Flat storage index
    function [9:0] mix;
        input [1:0] r;
        input [7:0] o;
        begin
            mix = {r, o}; // R1
        end
    endfunction

    srac_pin_sync #(.W(3)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .pin_in({SPI_CS_N, SPI_SCK, SPI_SI}),
        .init_val(3'h4),
        .level_out(pins_s)
    );

    wire busy = (st_r != ST_IDLE) | OTHER_BUSY;
    wire [23:0] adr_full = {adr_r[22:0], si_s};
    wire [1:0] rsel = adr_r[13:12];

    // Serial front end: shift, decode, stream
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            bcnt_r <= 6'h00;
            op_r <= 8'h00;
            adr_r <= 24'h000000;
            bit_r <= 3'h0;
            shin_r <= 8'h00;
            shout_r <= 8'h00;
            off_r <= 8'h00;
            in_data_r <= 1'b0;
            frame_ok_r <= 1'b0;
            byte_edge_r <= 1'b0;
            pval_r <= 256'h0;
            SPI_SO <= 1'b0;
            SPI_SO_OE <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
            cs_d_r <= cs_n_s;
            if (cs_n_s) begin
                // Idle between frames; output released
                bcnt_r <= 6'h00;
                bit_r <= 3'h0;
                in_data_r <= 1'b0;
                SPI_SO_OE <= 1'b0;
                if (!cs_d_r) begin
                    frame_ok_r <= 1'b0;
                    byte_edge_r <= 1'b0;
                end
            end else if (sck_rise) begin
                // Sample on rising edge
                if (!in_data_r) begin // R16
                    // Saturate so an overlong frame never decodes again
                    if (!(&bcnt_r))
                        bcnt_r <= bcnt_r + 6'h01;
                    // Fresh frame: forget bytes of an earlier program
                    if (bcnt_r == 6'h00 && st_r == ST_IDLE)
                        pval_r <= 256'h0;
                    if (bcnt_r < `SRAC_CNT_OP) begin
                        op_r <= {op_r[6:0], si_s};
                        // Frame counts only if idle through the opcode
                        frame_ok_r <= !busy &&
                            (frame_ok_r || bcnt_r == 6'h00); // R18
                    end else if (bcnt_r < `SRAC_CNT_ADR) begin
                        adr_r <= adr_full;
                    end
                    if (bcnt_r == `SRAC_CNT_ADR - 6'h01) begin
                        off_r <= adr_full[7:0];
                        byte_edge_r <= (op_r == `SRAC_OP_ERASE); // R6
                        if (op_r == `SRAC_OP_PROG)
                            in_data_r <= 1'b1;
                    end
                    if (op_r == `SRAC_OP_READ &&
                        bcnt_r == `SRAC_CNT_DUMMY - 6'h01) begin
                        in_data_r <= 1'b1;
                        shout_r <= mem[mix(rsel, off_r)];
                    end
                    if (bcnt_r >= `SRAC_CNT_ADR)
                        byte_edge_r <= 1'b0; // R6
                end else if (op_r == `SRAC_OP_PROG && frame_ok_r) begin
                    // Bytes of a frame begun while busy never load
                    bit_r <= bit_r + 3'h1;
                    shin_r <= {shin_r[6:0], si_s};
                    if (bit_r == 3'h7) begin
                        // Latch byte and wrap within the register
                        pbuf[off_r] <= {shin_r[6:0], si_s};
                        pval_r[off_r] <= 1'b1;
                        off_r <= off_r + 8'h01; // R21
                    end
                end
            end else if (sck_fall && in_data_r &&
                op_r == `SRAC_OP_READ && frame_ok_r) begin
                // Drive on falling edge, MSB first, until chip select
                SPI_SO_OE <= 1'b1; // R19
                SPI_SO <= shout_r[7]; // R16
                bit_r <= bit_r + 3'h1;
                if (bit_r == 3'h7) begin
                    off_r <= off_r + 8'h01; // R17
                    shout_r <= mem[mix(rsel, off_r + 8'h01)]; // R17
                end else begin
                    shout_r <= {shout_r[6:0], 1'b0};
                end
            end
        end
    end

    // Self-timed erase and program engine
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r <= ST_IDLE;
            tmr_r <= 32'h0;
            sel_r <= 2'h0;
            idx_r <= 9'h000;
            WEL_CLEAR <= 1'b0;
            SEC_BUSY <= 1'b0;
            for (i = 0; i < 1024; i = i + 1)
                mem[i] <= `SRAC_BYTE_ERASED;
        end else begin
            WEL_CLEAR <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    idx_r <= 9'h000;
                    if (cs_rise && !busy && frame_ok_r &&
                        WRITE_ENABLE_LATCH &&
                        adr_valid(adr_r)) begin // R2 R13
                        sel_r <= rsel;
                        if (op_r == `SRAC_OP_ERASE && byte_edge_r &&
                            !SECURITY_LOCK_BITS[rsel]) begin // R10
                            st_r <= ST_ERASE; // R7
                            tmr_r <= ERASE_CYC;
                            SEC_BUSY <= 1'b1; // R8
                        end else if (op_r == `SRAC_OP_PROG &&
                            pval_r != 256'h0 &&
                            !SECURITY_LOCK_BITS[rsel]) begin // R11
                            st_r <= ST_PROG; // R20
                            tmr_r <= PROG_CYC;
                            SEC_BUSY <= 1'b1; // R20
                        end
                    end
                end
                ST_ERASE, ST_PROG: begin
                    // Apply one byte per cycle, then wait out the time
                    if (!idx_r[8]) begin
                        idx_r <= idx_r + 9'h001;
                        if (st_r == ST_ERASE)
                            mem[mix(sel_r, idx_r[7:0])] <=
                                `SRAC_BYTE_ERASED;
                        else if (pval_r[idx_r[7:0]])
                            mem[mix(sel_r, idx_r[7:0])] <=
                                mem[mix(sel_r, idx_r[7:0])] &
                                pbuf[idx_r[7:0]]; // R21 R12
                    end
                    if (tmr_r > 32'h1) begin
                        tmr_r <= tmr_r - 32'h1;
                    end else if (idx_r[8]) begin
                        st_r <= ST_IDLE;
                        SEC_BUSY <= 1'b0; // R8
                        WEL_CLEAR <= 1'b1; // R9 R20
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [rtl/srac_defines.vh]
// Constants for the security register access block.
// Assumes inclusion by the block's design files and its bench.
`ifndef SRAC_DEFINES_VH
`define SRAC_DEFINES_VH
// Instruction codes
`define SRAC_OP_ERASE 8'h44
`define SRAC_OP_PROG 8'h42
`define SRAC_OP_READ 8'h48
// Address fields
`define SRAC_ADR_HI_VAL 8'h00
`define SRAC_ADR_MID_VAL 4'h0
`define SRAC_REG_MAX 4'h3
// Frame bit counts: opcode, opcode plus address, plus dummy byte
`define SRAC_CNT_OP 6'h08
`define SRAC_CNT_ADR 6'h20
`define SRAC_CNT_DUMMY 6'h28
// Byte values
`define SRAC_BYTE_ERASED 8'hff
`define SRAC_BYTE_FIRST 8'h00
// Self-timed cycle times in microseconds, system clock in MHz (plain defaults)
`define SRAC_ERASE_TIME_US 100
`define SRAC_PROG_TIME_US 50
`define SRAC_CLK_MHZ 10
`endif

// [rtl/srac_pin_sync.v]
// Three-stage synchroniser for the serial pins.
// Assumes pins are asynchronous to CLK_SYS; a change counts once the
// second and third stages agree.
`default_nettype none
module srac_pin_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pins and settled levels
    input wire [W-1:0] pin_in,
    input wire [W-1:0] init_val,
    output reg [W-1:0] level_out
);
    reg [W-1:0] s1_r; // First stage, read only by s2
    reg [W-1:0] s2_r; // Second stage
    reg [W-1:0] s3_r; // Third stage
    // Shift chain and agreement filter
    always @(posedge clk) begin
        if (!rst_n) begin
            // Start at the pins' idle levels so no false edge follows
            s1_r <= init_val;
            s2_r <= init_val;
            s3_r <= init_val;
            level_out <= init_val;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Per bit: take stage two once it agrees with stage three
            level_out <= (level_out & (s2_r ^ s3_r)) |
                (s2_r & ~(s2_r ^ s3_r));
        end
    end
endmodule
`default_nettype wire

// [verif/srac_chk.sv]
// Checker for the security register block, all in the CLK_SYS domain.
// Assumes it is bound to srac_top and sees only its ports.
`default_nettype none
module srac_chk #(
    parameter PROG_CYC = 500
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Serial pins
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic SPI_SO,
    input wire logic SPI_SO_OE,
    // Status links
    input wire logic WRITE_ENABLE_LATCH,
    input wire logic OTHER_BUSY,
    input wire logic WEL_CLEAR,
    input wire logic SEC_BUSY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Length of the running busy stretch
    int busy_cnt_r;
    always @(posedge CLK_SYS) busy_cnt_r <= SEC_BUSY ? busy_cnt_r + 1 : 0;
    // Cycle end: busy low with the latch clear pulse
    sequence s_done;
        !SEC_BUSY ##0 WEL_CLEAR;
    endsequence
    property p_start;
        $rose(SEC_BUSY) |-> SPI_CS_N && $past(SPI_CS_N, 2);
    endproperty
    a_start: assert property (p_start) else $error("busy without end");
    property p_wel;
        $rose(SEC_BUSY) |-> WRITE_ENABLE_LATCH && !OTHER_BUSY;
    endproperty
    a_wel: assert property (p_wel) else $error("cycle not allowed");
    property p_len;
        $fell(SEC_BUSY) |-> busy_cnt_r >= PROG_CYC;
    endproperty
    a_len: assert property (p_len) else $error("busy too short");
    property p_done;
        $fell(SEC_BUSY) |-> s_done;
    endproperty
    a_done: assert property (p_done) else $error("no latch clear");
    property p_clr;
        WEL_CLEAR |-> $fell(SEC_BUSY) ##1 !WEL_CLEAR;
    endproperty
    a_clr: assert property (p_clr) else $error("stray latch clear");
    property p_oe;
        $rose(SPI_SO_OE) |-> !SEC_BUSY && !OTHER_BUSY && !SPI_CS_N;
    endproperty
    a_oe: assert property (p_oe) else $error("output while busy");
    property p_so;
        $changed(SPI_SO) |-> !SPI_SCK;
    endproperty
    a_so: assert property (p_so) else $error("data moved off fall");
    property p_busy_oe;
        SEC_BUSY |-> !SPI_SO_OE;
    endproperty
    a_busy_oe: assert property (p_busy_oe) else $error("read in cycle");
    property p_end;
        SPI_CS_N [*8] |-> !SPI_SO_OE;
    endproperty
    a_end: assert property (p_end) else $error("output after end");
endmodule
bind srac_top srac_chk #(.PROG_CYC(PROG_CYC)) i_chk (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK),
    .SPI_SO(SPI_SO), .SPI_SO_OE(SPI_SO_OE),
    .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .OTHER_BUSY(OTHER_BUSY),
    .WEL_CLEAR(WEL_CLEAR), .SEC_BUSY(SEC_BUSY));
`default_nettype wire

// [verif/srac_host.sv]
// Host model: mode 0 serial master, SCK stands still outside frames.
// Assumes the bench calls its tasks; half period is 8 CLK_SYS cycles.
`default_nettype none
module srac_host (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // One half period of the serial clock
    task automatic hold();
        repeat (8) @(posedge clk);
    endtask
    // Frame start
    task automatic cs_lo();
        hold();
        cs_n <= 1'b0;
        hold();
    endtask
    // Frame end after the last bit sent, whole byte or not; data line no longer valid
    task automatic cs_hi();
        hold();
        cs_n <= 1'b1;
        si <= ~si;
        hold();
        hold();
    endtask
    // Shift n bits MSB first, sample SO just before each rise
    task automatic xb(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si <= b[i];
            hold();
            r[i] = so;
            sck <= 1'b1;
            hold();
            sck <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// [verif/srac_tb_top.sv]
// Bench for srac_top: random data bytes with fixed refusal cases.
// Assumes the latch, lock bits and other-busy level are driven here.
`default_nettype none
`include "srac_defines.vh"
module srac_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EC = 1000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic write_enable_latch = 1'b0;
    logic [3:0] lock = 4'h0;
    logic oth = 1'b0;
    logic [7:0] op;
    wire cs_n, sck, si, so, so_oe, wel_clr, busy;
    logic [7:0] mem [4][256];
    logic [7:0] dat[$];
    logic [7:0] rd[$];
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int oe_cnt = 0;
    int r;
    int n;
    always #50 clk = ~clk;
    srac_top #(.ERASE_CYC(EC), .PROG_CYC(500)) i_dut (.CLK_SYS(clk),
        .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SI(si),
        .SPI_SO(so), .SPI_SO_OE(so_oe), .WRITE_ENABLE_LATCH(write_enable_latch),
        .SECURITY_LOCK_BITS(lock), .OTHER_BUSY(oth), .WEL_CLEAR(wel_clr),
        .SEC_BUSY(busy));
    srac_host i_host (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
    // Counts cycles with the data output driven; cuts a hang short
    always @(posedge clk) begin
        oe_cnt <= oe_cnt + (so_oe === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    function automatic logic [23:0] adr(input int g, input logic [7:0] o);
        return {8'h00, 2'b00, g[1:0], 4'h0, o};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Whole frame: opcode, address, extra bits, data, then reads
    task automatic frm(input logic [7:0] o, input logic [23:0] a,
        input int ex, input int nrd);
        logic [7:0] b;
        rd = {};
        i_host.cs_lo();
        i_host.xb(o, 8, b);
        for (int i = 2; i >= 0; i--) i_host.xb(a[8*i+:8], 8, b);
        if (ex > 0) i_host.xb(8'h5a, ex, b);
        foreach (dat[i]) i_host.xb(dat[i], 8, b);
        if (nrd > 0) i_host.xb(8'h00, 8, b);
        repeat (nrd) begin
            i_host.xb(8'h00, 8, b);
            rd.push_back(b);
        end
        i_host.cs_hi();
    endtask
    // Busy seen or not, and exactly one latch clear if seen
    task automatic chk_cyc(input logic e);
        int nb = 0;
        int nc = 0;
        repeat (EC + 100) begin
            @(negedge clk);
            nb += (busy === 1'b1);
            nc += (wel_clr === 1'b1);
        end
        cmp(8'(nb > 0), 8'(e));
        cmp(8'(nc), 8'(e));
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] o, input int k);
        int m;
        m = oe_cnt;
        dat = {};
        frm(`SRAC_OP_READ, adr(r, o), 0, k);
        cmp(8'(oe_cnt > m), 8'h01);
        cmp(8'(so_oe), 8'h00);
        foreach (rd[i]) cmp(rd[i], mem[r][8'(o + i)]);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(17));
        foreach (mem[g, o]) mem[g][o] = 8'hff;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        write_enable_latch <= 1'b1;
        r = 1 + $urandom % 3;
        rdchk(8'hfe, 3);
        // Two programs at the top offset: wrap and bit clearing
        repeat (2) begin
            dat = {8'($urandom), 8'($urandom)};
            frm(`SRAC_OP_PROG, adr(r, 8'hff), 0, 0);
            chk_cyc(1'b1);
            foreach (dat[i]) mem[r][8'(8'hff + i)] &= dat[i];
            rdchk(8'hfe, 4);
        end
        // Refused cases: no latch, locked, bad address, extra bit, busy
        for (int k = 0; k < 7; k++) begin
            write_enable_latch <= !(k == 0 || k == 3);
            lock <= (k == 1 || k == 4) ? 4'(1 << r) : 4'h0;
            oth <= (k == 6);
            dat = {8'h00};
            op = `SRAC_OP_PROG;
            if (k inside {3, 4, 5}) begin
                dat = {};
                op = `SRAC_OP_ERASE;
            end
            frm(op, adr(r, 8'h00) | (k == 2 ? 24'h000100 : 24'h0),
                k == 5 ? 1 : 0, 0);
            chk_cyc(1'b0);
        end
        write_enable_latch <= 1'b1;
        lock <= 4'h0;
        oth <= 1'b0;
        rdchk(8'hfe, 4);
        frm(`SRAC_OP_ERASE, adr(r, 8'h5a), 0, 0);
        chk_cyc(1'b1);
        for (int o = 0; o < 256; o++) mem[r][o] = 8'hff;
        rdchk(8'hff, 2);
        // Read issued during an erase is ignored
        frm(`SRAC_OP_ERASE, adr(r, 8'h00), 0, 0);
        n = oe_cnt;
        frm(`SRAC_OP_READ, adr(r, 8'h00), 0, 1);
        cmp(8'(oe_cnt - n), 8'h00);
        repeat (EC) @(posedge clk);
        rdchk(8'h00, 1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
